// ---- verilog/gpio_expander.sv ----
// Top of the 8-bit two-wire GPIO expander: registers, pins and interrupt
//
// Overview of operation
// - Interrupt asserts when an unmasked input differs from the input register.
// - Interrupt pin is open-drain, pulled low when active, released otherwise.
// - All interrupt mask bits are set after reset.
// - All port pins are inputs after reset, nothing driven.
// - Reset puts every register at its default value.
// - Direction, input, output and polarity registers are eight bits each.
// - Three strap pins give the low slave address bits.
// - Latched pin holds captured change until input register is read.
// - A set mask bit stops that pin raising the interrupt.
// - Read-only status register shows which pins caused the interrupt.
// - One bank bit chooses push-pull or open-drain outputs.
// - Each output pin has a two-bit drive strength setting.
// - Per-pin enable connects the pull resistor or leaves input floating.
// - Per-pin select bit chooses pull-up or pull-down.
// - Output levels stay stored until the master writes new data.
// - Command byte after address is stored as write-only register pointer.
// - Address byte LSB set means read, clear means write.
// - Input register reflects pin levels whether input or output.
`timescale 1ns/1ps
module gpio_expander (
	input  wire logic                            mclk,
	input  wire logic                            reset,
	input  wire logic                            scl_in,
	input  wire logic                            sda_in,
	output logic                                 sda_out,
	output logic                                 sda_oe,
	input  wire logic                            addr_strap_bit0,
	input  wire logic                            addr_strap_bit1,
	input  wire logic                            addr_strap_bit2,
	input  wire logic [gpio_exp_pkg::DATA_W-1:0] port_in,
	output logic      [gpio_exp_pkg::DATA_W-1:0] port_out,
	output logic      [gpio_exp_pkg::DATA_W-1:0] port_oe,
	output logic      [gpio_exp_pkg::DATA_W-1:0] pull_en,
	output logic      [gpio_exp_pkg::DATA_W-1:0] pull_up,
	output logic      [gpio_exp_pkg::DATA_W-1:0] drive_lo,
	output logic      [gpio_exp_pkg::DATA_W-1:0] drive_hi,
	output logic                                 int_out,
	output logic                                 int_oe
);
	import gpio_exp_pkg::*;

	reg_bus_if bus ();

	logic [DATA_W-1:0] pin_s1_ff;
	logic [DATA_W-1:0] pin_s2_ff;
	logic [2:0]        strap_s1_ff;
	logic [2:0]        strap_s2_ff;
	logic [DATA_W-1:0] in_reg_ff;
	logic [DATA_W-1:0] out_ff;
	logic [DATA_W-1:0] pol_ff;
	logic [DATA_W-1:0] cfg_ff;
	logic [DATA_W-1:0] drv0_ff;
	logic [DATA_W-1:0] drv1_ff;
	logic [DATA_W-1:0] latch_ff;
	logic [DATA_W-1:0] pen_ff;
	logic [DATA_W-1:0] psel_ff;
	logic [DATA_W-1:0] mask_ff;
	logic [DATA_W-1:0] held_ff;
	logic [DATA_W-1:0] stat_ff;
	logic              odrain_ff;
	logic [DATA_W-1:0] rdata_ff;
	logic [DATA_W-1:0] pin_val;
	logic [DATA_W-1:0] diff;
	logic [DATA_W-1:0] nxt_in_reg;
	logic [DATA_W-1:0] nxt_held;
	logic              in_read;

	// Pins are asynchronous to mclk
	always_ff @(posedge mclk) begin
		if (reset) begin
			pin_s1_ff <= RST_ZEROS;
			pin_s2_ff <= RST_ZEROS;
		end else begin
			pin_s1_ff <= port_in;
			pin_s2_ff <= pin_s1_ff;
		end
	end

	// Straps are meant to be static, but a board may move them live;
	// two flops each keep a moving strap from splitting the address match
	always_ff @(posedge mclk) begin
		if (reset) begin
			strap_s1_ff <= RST_ZEROS[2:0];
			strap_s2_ff <= RST_ZEROS[2:0];
		end else begin
			strap_s1_ff <= {addr_strap_bit2, addr_strap_bit1,
				addr_strap_bit0};
			strap_s2_ff <= strap_s1_ff;
		end
	end

	i2c_slave_link u_link (
		.mclk       (mclk),
		.reset      (reset),
		.scl_in     (scl_in),
		.sda_in     (sda_in),
		.sda_oe     (sda_oe),
		.addr_strap (strap_s2_ff),
		.bus        (bus.link)
	);

	// Pin level after polarity, whatever the direction
	assign pin_val = pin_s2_ff ^ pol_ff;
	assign diff    = pin_val ^ in_reg_ff;
	assign in_read = bus.rd && bus.ptr == CMD_INPUT;

	// Latched pins hold a change until read; others track the pin
	always_comb begin
		nxt_held   = held_ff;
		nxt_in_reg = in_reg_ff;
		if (in_read) begin
			nxt_held = RST_ZEROS;
		end
		for (int i = 0; i < DATA_W; i++) begin
			if (!nxt_held[i]) begin
				nxt_in_reg[i] = pin_val[i];
				if (latch_ff[i] && diff[i]) begin
					nxt_held[i] = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			in_reg_ff <= RST_ZEROS;
			held_ff   <= RST_ZEROS;
		end else begin
			in_reg_ff <= nxt_in_reg;
			held_ff   <= nxt_held;
		end
	end

	// Status collects unmasked changes; a new change beats the read clear
	always_ff @(posedge mclk) begin
		if (reset) begin
			stat_ff <= RST_ZEROS;
		end else begin
			stat_ff <= (in_read ? RST_ZEROS : stat_ff) | (diff & ~mask_ff);
		end
	end

	// Register writes; output data held until rewritten
	always_ff @(posedge mclk) begin
		if (reset) begin
			out_ff    <= RST_ONES;
			pol_ff    <= RST_ZEROS;
			cfg_ff    <= RST_ONES;
		end else if (bus.wr) begin
			unique case (bus.ptr)
			CMD_OUTPUT:   out_ff    <= bus.wdata;
			CMD_POLARITY: pol_ff    <= bus.wdata;
			CMD_CONFIG:   cfg_ff    <= bus.wdata;
			default: ;
			endcase
		end
	end

	// Extended pin features sit in their own block
	always_ff @(posedge mclk) begin
		if (reset) begin
			drv0_ff   <= RST_ONES;
			drv1_ff   <= RST_ONES;
			latch_ff  <= RST_ZEROS;
			pen_ff    <= RST_ZEROS;
			psel_ff   <= RST_ONES;
			mask_ff   <= RST_ONES;
			odrain_ff <= 1'b0;
		end else if (bus.wr) begin
			unique case (bus.ptr)
			CMD_DRIVE0:   drv0_ff   <= bus.wdata;
			CMD_DRIVE1:   drv1_ff   <= bus.wdata;
			CMD_LATCH:    latch_ff  <= bus.wdata;
			CMD_PULL_EN:  pen_ff    <= bus.wdata;
			CMD_PULL_SEL: psel_ff   <= bus.wdata;
			CMD_INT_MASK: mask_ff   <= bus.wdata;
			CMD_OUT_CONF: odrain_ff <= bus.wdata[0];
			default: ;
			endcase
		end
	end

	// Read data registered on the read strobe; pointer itself reads nowhere
	always_ff @(posedge mclk) begin
		if (reset) begin
			rdata_ff <= RST_ZEROS;
		end else if (bus.rd) begin
			unique case (bus.ptr)
			CMD_INPUT:    rdata_ff <= in_reg_ff;
			CMD_OUTPUT:   rdata_ff <= out_ff;
			CMD_POLARITY: rdata_ff <= pol_ff;
			CMD_CONFIG:   rdata_ff <= cfg_ff;
			CMD_DRIVE0:   rdata_ff <= drv0_ff;
			CMD_DRIVE1:   rdata_ff <= drv1_ff;
			CMD_LATCH:    rdata_ff <= latch_ff;
			CMD_PULL_EN:  rdata_ff <= pen_ff;
			CMD_PULL_SEL: rdata_ff <= psel_ff;
			CMD_INT_MASK: rdata_ff <= mask_ff;
			CMD_INT_STAT: rdata_ff <= stat_ff;
			CMD_OUT_CONF: rdata_ff <= {7'h00, odrain_ff};
			default:      rdata_ff <= RST_ZEROS;
			endcase
		end
	end
	assign bus.rdata = rdata_ff;

	// Open-drain mode drives only low levels
	assign port_out = out_ff;
	assign port_oe  = ~cfg_ff & (odrain_ff ? ~out_ff : RST_ONES);
	assign pull_en  = pen_ff;
	assign pull_up  = psel_ff;
	assign drive_lo = drv0_ff;
	assign drive_hi = drv1_ff;
	assign sda_out  = 1'b0;
	assign int_out  = 1'b0;
	assign int_oe   = |stat_ff;
endmodule : gpio_expander

// ---- verilog/gpio_exp_pkg.sv ----
// Constants and types shared by the two-wire GPIO expander
package gpio_exp_pkg;
	localparam int          DATA_W        = 8;
	localparam logic [3:0]  ADDR_BASE     = 4'h4;
	localparam logic [7:0]  CMD_INPUT     = 8'h00;
	localparam logic [7:0]  CMD_OUTPUT    = 8'h01;
	localparam logic [7:0]  CMD_POLARITY  = 8'h02;
	localparam logic [7:0]  CMD_CONFIG    = 8'h03;
	localparam logic [7:0]  CMD_DRIVE0    = 8'h40;
	localparam logic [7:0]  CMD_DRIVE1    = 8'h41;
	localparam logic [7:0]  CMD_LATCH     = 8'h42;
	localparam logic [7:0]  CMD_PULL_EN   = 8'h43;
	localparam logic [7:0]  CMD_PULL_SEL  = 8'h44;
	localparam logic [7:0]  CMD_INT_MASK  = 8'h45;
	localparam logic [7:0]  CMD_INT_STAT  = 8'h46;
	localparam logic [7:0]  CMD_OUT_CONF  = 8'h4F;
	localparam logic [7:0]  RST_ONES      = 8'hFF;
	localparam logic [7:0]  RST_ZEROS     = 8'h00;
	localparam logic [2:0]  BIT_LAST      = 3'h0;
	localparam logic [2:0]  BIT_FIRST     = 3'h7;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_ADDR  = 3'b001,
		ST_ACK   = 3'b010,
		ST_WRITE = 3'b011,
		ST_READ  = 3'b100,
		ST_RACK  = 3'b101
	} link_state_t;
endpackage : gpio_exp_pkg

// ---- verilog/reg_bus_if.sv ----
// Byte-wide register access between the link engine and the register file
`timescale 1ns/1ps
interface reg_bus_if;
	logic       wr;
	logic       rd;
	logic [7:0] ptr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport link (output wr, output rd, output ptr, output wdata,
		input rdata);
	modport regs (input wr, input rd, input ptr, input wdata,
		output rdata);
endinterface : reg_bus_if

// ---- verilog/i2c_slave_link.sv ----
// Two-wire serial slave engine: address, pointer, byte writes and reads
`timescale 1ns/1ps
module i2c_slave_link (
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_oe,
	input  wire logic [2:0]  addr_strap,
	reg_bus_if.link          bus
);
	import gpio_exp_pkg::*;

	logic [1:0]  scl_sync_ff;
	logic [1:0]  sda_sync_ff;
	logic        scl_d_ff;
	logic        sda_d_ff;
	link_state_t state_ff;
	logic [7:0]  shift_ff;
	logic [2:0]  bit_ff;
	logic        rnw_ff;
	logic        have_ptr_ff;
	logic        nack_ff;
	logic        rise_seen_ff;
	logic [7:0]  ptr_ff;
	logic        wr_ff;
	logic        rd_ff;
	logic        sda_oe_ff;
	logic        scl_s;
	logic        sda_s;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_c;
	logic        stop_c;

	// Pins are asynchronous to mclk
	always_ff @(posedge mclk) begin
		if (reset) begin
			scl_sync_ff <= 2'h3;
			sda_sync_ff <= 2'h3;
			scl_d_ff    <= 1'b1;
			sda_d_ff    <= 1'b1;
		end else begin
			scl_sync_ff <= {scl_sync_ff[0], scl_in};
			sda_sync_ff <= {sda_sync_ff[0], sda_in};
			scl_d_ff    <= scl_sync_ff[1];
			sda_d_ff    <= sda_sync_ff[1];
		end
	end

	// 40 MHz sampling leaves ~100 samples per 400 kHz bit
	assign scl_s    = scl_sync_ff[1];
	assign sda_s    = sda_sync_ff[1];
	assign scl_rise = scl_s & ~scl_d_ff;
	assign scl_fall = ~scl_s & scl_d_ff;
	assign start_c  = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
	assign stop_c   = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

	always_ff @(posedge mclk) begin
		if (reset) begin
			state_ff    <= ST_IDLE;
			shift_ff    <= RST_ZEROS;
			bit_ff      <= BIT_FIRST;
			rnw_ff      <= 1'b0;
			have_ptr_ff <= 1'b0;
			nack_ff     <= 1'b0;
			rise_seen_ff <= 1'b0;
			ptr_ff      <= CMD_INPUT;
			wr_ff       <= 1'b0;
			rd_ff       <= 1'b0;
			sda_oe_ff   <= 1'b0;
		end else begin
			wr_ff <= 1'b0;
			rd_ff <= 1'b0;
			if (start_c) begin
				state_ff  <= ST_ADDR;
				bit_ff    <= BIT_FIRST;
				rise_seen_ff <= 1'b0;
				sda_oe_ff <= 1'b0;
			end else if (stop_c) begin
				state_ff  <= ST_IDLE;
				sda_oe_ff <= 1'b0;
			end else begin
				unique case (state_ff)
				ST_IDLE: begin
				end
				ST_ADDR, ST_WRITE: begin
					if (scl_rise) begin
						shift_ff     <= {shift_ff[6:0], sda_s};
						rise_seen_ff <= 1'b1;
					end
					// The clock fall that closes a START carries no bit
					if (scl_fall && rise_seen_ff && bit_ff == BIT_LAST) begin
						if (state_ff == ST_ADDR) begin
							// Upper nibble fixed, strap bits below, R/W last
							if (shift_ff[7:1] == {ADDR_BASE, addr_strap}) begin
								rnw_ff      <= shift_ff[0];
								have_ptr_ff <= 1'b0;
								sda_oe_ff   <= 1'b1;
								state_ff    <= ST_ACK;
								if (shift_ff[0]) begin
									rd_ff <= 1'b1;
								end
							end else begin
								state_ff <= ST_IDLE;
							end
						end else begin
							if (!have_ptr_ff) begin
								ptr_ff      <= shift_ff;
								have_ptr_ff <= 1'b1;
							end else begin
								wr_ff <= 1'b1;
							end
							sda_oe_ff <= 1'b1;
							state_ff  <= ST_ACK;
						end
					end else if (scl_fall && rise_seen_ff) begin
						bit_ff <= bit_ff - 3'h1;
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						bit_ff <= BIT_FIRST;
						if (rnw_ff) begin
							shift_ff  <= bus.rdata;
							sda_oe_ff <= ~bus.rdata[7];
							state_ff  <= ST_READ;
						end else begin
							sda_oe_ff <= 1'b0;
							state_ff  <= ST_WRITE;
						end
					end
				end
				ST_READ: begin
					if (scl_fall) begin
						if (bit_ff == BIT_LAST) begin
							sda_oe_ff <= 1'b0;
							state_ff  <= ST_RACK;
						end else begin
							bit_ff    <= bit_ff - 3'h1;
							shift_ff  <= {shift_ff[6:0], 1'b0};
							sda_oe_ff <= ~shift_ff[6];
						end
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						nack_ff <= sda_s;
						if (!sda_s) begin
							rd_ff <= 1'b1;
						end
					end
					// Next byte must be on the line as soon as the ack ends
					if (scl_fall) begin
						bit_ff    <= BIT_FIRST;
						shift_ff  <= bus.rdata;
						sda_oe_ff <= ~nack_ff & ~bus.rdata[7];
						state_ff  <= nack_ff ? ST_IDLE : ST_READ;
					end
				end
				default: state_ff <= ST_IDLE;
				endcase
			end
		end
	end

	assign sda_oe    = sda_oe_ff;
	assign bus.wr    = wr_ff;
	assign bus.rd    = rd_ff;
	assign bus.ptr   = ptr_ff;
	assign bus.wdata = shift_ff;
endmodule : i2c_slave_link

// ---- sim/gpio_expander_assertions.sv ----
// Concurrent checks on the expander's pins
`timescale 1ns/1ps
module gpio_expander_assertions (
	input wire logic       mclk,
	input wire logic       reset,
	input wire logic       scl_in,
	input wire logic       sda_in,
	input wire logic       sda_out,
	input wire logic       sda_oe,
	input wire logic [7:0] port_in,
	input wire logic [7:0] port_out,
	input wire logic [7:0] port_oe,
	input wire logic [7:0] pull_en,
	input wire logic [7:0] pull_up,
	input wire logic [7:0] drive_lo,
	input wire logic [7:0] drive_hi,
	input wire logic       int_out,
	input wire logic       int_oe
);
	logic [3:0] quiet_ff;
	logic [3:0] low_age_ff;
	logic       acked_ff;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	// Ages saturate so long idle stretches never wrap round
	always_ff @(posedge mclk) begin
		if (reset || port_in != $past(port_in)) quiet_ff <= 4'h0;
		else if (quiet_ff != 4'hF) quiet_ff <= quiet_ff + 4'h1;
	end
	always_ff @(posedge mclk) begin
		if (reset || !sda_in) low_age_ff <= 4'h0;
		else if (low_age_ff != 4'hF) low_age_ff <= low_age_ff + 4'h1;
	end
	always_ff @(posedge mclk) begin
		if (reset) acked_ff <= 1'b0;
		else if (sda_oe) acked_ff <= 1'b1;
	end
	sequence ack_soon;
		##[0:6] sda_oe;
	endsequence
	sequence rst_vals;
		port_oe == 8'h00 && port_out == 8'hFF && pull_en == 8'h00
		&& pull_up == 8'hFF && drive_lo == 8'hFF && drive_hi == 8'hFF
		&& !int_oe;
	endsequence
	a_rst_values: assert property ($fell(reset) |-> rst_vals)
		else $error("outputs not at reset values");
	a_masked_boot: assert property (!acked_ff |-> !int_oe)
		else $error("interrupt before any bus write");
	a_int_cause: assert property ($rose(int_oe) |-> quiet_ff < 4'hA)
		else $error("interrupt without pin change");
	a_int_clear: assert property ($fell(int_oe) |-> low_age_ff < 4'hC)
		else $error("interrupt cleared outside a read");
	a_regs_on_ack: assert property ($changed({port_out, port_oe, pull_en,
		pull_up, drive_lo, drive_hi}) |-> ack_soon)
		else $error("pin setting changed outside a write");
	a_sda_high_hold: assert property (scl_in && $past(scl_in, 2)
		|-> $stable(sda_oe))
		else $error("data line moved while clock high");
	a_sda_out_low: assert property (sda_out == 1'b0)
		else $error("data pin drives high");
	a_int_pin_low: assert property (int_out == 1'b0)
		else $error("interrupt pin drives high");
endmodule : gpio_expander_assertions

bind gpio_expander gpio_expander_assertions chk (
	.mclk, .reset, .scl_in, .sda_in, .sda_out, .sda_oe, .port_in,
	.port_out, .port_oe, .pull_en, .pull_up, .drive_lo, .drive_hi,
	.int_out, .int_oe
);

// ---- sim/i2c_master_model.sv ----
// Behavioural two-wire bus master on an open-drain data line
`timescale 1ns/1ps
module i2c_master_model (
	input  wire logic mclk,
	input  wire logic sda_oe,
	output logic      scl,
	output logic      sda
);
	logic m_low;
	// Wired-AND with pull-up, so a released line reads high, never unknown
	assign sda = ~(m_low | sda_oe);
	initial begin
		scl = 1'b1;
		m_low = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask : tick
	// Data moves mid low phase; clock stands high between frames
	task automatic bit_io(input logic b, output logic r);
		tick(2);
		m_low <= ~b;
		tick(2);
		scl <= 1'b1;
		tick(4);
		r = sda;
		scl <= 1'b0;
	endtask : bit_io
	task automatic start();
		tick(2);
		m_low <= 1'b0;
		tick(2);
		scl <= 1'b1;
		tick(4);
		m_low <= 1'b1;
		tick(4);
		scl <= 1'b0;
	endtask : start
	task automatic stop();
		tick(2);
		m_low <= 1'b1;
		tick(2);
		scl <= 1'b1;
		tick(4);
		m_low <= 1'b0;
		tick(4);
	endtask : stop
	task automatic wr_byte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(b[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask : wr_byte
	task automatic wr_reg(input logic [6:0] a, input logic [7:0] c,
		input logic [7:0] v, output logic ok);
		logic k1, k2, k3;
		start();
		wr_byte({a, 1'b0}, k1);
		wr_byte(c, k2);
		wr_byte(v, k3);
		stop();
		ok = k1 & k2 & k3;
	endtask : wr_reg
	task automatic rd_reg(input logic [6:0] a, input logic [7:0] c,
		output logic [7:0] d);
		logic k;
		start();
		wr_byte({a, 1'b0}, k);
		wr_byte(c, k);
		start();
		wr_byte({a, 1'b1}, k);
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(1'b1, k);
		stop();
	endtask : rd_reg
	// Two bytes in one read: master acks the first, nacks the second
	task automatic rd_two(input logic [6:0] a, input logic [7:0] c,
		output logic [7:0] d0, output logic [7:0] d1);
		logic k;
		start();
		wr_byte({a, 1'b0}, k);
		wr_byte(c, k);
		start();
		wr_byte({a, 1'b1}, k);
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d0[i]);
		bit_io(1'b0, k);
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d1[i]);
		bit_io(1'b1, k);
		stop();
	endtask : rd_two
endmodule : i2c_master_model

// ---- sim/gpio_expander_test.sv ----
// Self-checking bench for the two-wire GPIO expander
`timescale 1ns/1ps
module gpio_expander_test;
	import gpio_exp_pkg::*;
	logic        mclk = 1'b0;
	logic        reset = 1'b1;
	logic        scl, sda, sda_out, sda_oe, int_out, int_oe, ok;
	logic [2:0]  strap;
	logic [6:0]  dev;
	logic [7:0]  port_in, port_out, port_oe, pull_en, pull_up;
	logic [7:0]  drive_lo, drive_hi, d, a, b, v;
	logic [7:0]  sh [8];
	logic [7:0]  cmds [12] = '{CMD_OUTPUT, CMD_POLARITY, CMD_CONFIG,
		CMD_DRIVE0, CMD_DRIVE1, CMD_LATCH, CMD_PULL_EN, CMD_PULL_SEL,
		CMD_INT_MASK, CMD_INT_STAT, CMD_OUT_CONF, 8'h4A};
	logic [11:0] rst_ones = 12'h19D;
	integer      seed = 15;
	int          err_count = 0;
	int          checked = 0;
	int          cycles = 0;
	always #12.5 mclk = ~mclk;
	gpio_expander dut (
		.mclk, .reset, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe,
		.addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]),
		.addr_strap_bit2(strap[2]), .port_in, .port_out, .port_oe,
		.pull_en, .pull_up, .drive_lo, .drive_hi, .int_out, .int_oe
	);
	i2c_master_model m (.mclk, .sda_oe, .scl, .sda);
	function automatic logic [7:0] exp_oe(logic [7:0] cfg, logic oc,
		logic [7:0] o);
		return oc ? ~cfg & ~o : ~cfg;
	endfunction : exp_oe
	function automatic logic [7:0] exp_in(logic [7:0] p, logic [7:0] n);
		return p ^ n;
	endfunction : exp_in
	task automatic cmp(input string n, input logic [7:0] e,
		input logic [7:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : cmp
	task automatic summarize();
		$display("checked %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : summarize
	task automatic wr(input logic [7:0] c, input logic [7:0] x);
		m.wr_reg(dev, c, x, ok);
		cmp("write ack", 8'h01, {7'h00, ok});
	endtask : wr
	task automatic rd(input logic [7:0] c, output logic [7:0] x);
		m.rd_reg(dev, c, x);
	endtask : rd
	task automatic pins(input logic [7:0] oe, o, pe, pu, dl, dh);
		cmp("port_oe", oe, port_oe);
		cmp("port_out", o, port_out);
		cmp("pull_en", pe, pull_en);
		cmp("pull_up", pu, pull_up);
		cmp("drive_lo", dl, drive_lo);
		cmp("drive_hi", dh, drive_hi);
	endtask : pins
	// Budget is roughly three times the expected run length
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 50000) begin
			err_count++;
			summarize();
		end
	end
	initial begin
		strap = 3'($random(seed));
		port_in = 8'($random(seed));
		dev = {ADDR_BASE, strap};
		repeat (4) @(posedge mclk);
		reset <= 1'b0;
		repeat (4) @(posedge mclk);
		pins(RST_ZEROS, RST_ONES, RST_ZEROS, RST_ONES, RST_ONES, RST_ONES);
		cmp("int_oe", 8'h00, {7'h00, int_oe});
		for (int i = 0; i < 12; i++) begin
			rd(cmds[i], d);
			cmp("reset value", {8{rst_ones[i]}}, d);
		end
		for (int i = 0; i < 8; i++) begin
			sh[i] = 8'($random(seed));
			wr(cmds[i], sh[i]);
			rd(cmds[i], d);
			cmp("readback", sh[i], d);
		end
		for (int j = 1; j >= 0; j--) begin
			wr(CMD_OUT_CONF, 8'(j));
			pins(exp_oe(sh[2], j[0], sh[0]), sh[0], sh[6], sh[7], sh[3],
				sh[4]);
		end
		wr(CMD_INT_STAT, RST_ONES);
		rd(CMD_INT_STAT, d);
		cmp("status ro", 8'h00, d);
		wr(CMD_LATCH, RST_ZEROS);
		for (int i = 0; i < 5; i++) begin
			a = 8'($random(seed));
			b = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
			wr(CMD_INT_MASK, b);
			@(posedge mclk) port_in <= a;
			repeat (10) @(posedge mclk);
			rd(CMD_INPUT, d);
			cmp("input", exp_in(a, sh[1]), d);
			cmp("int cleared", 8'h00, {7'h00, int_oe});
			v = 8'($random(seed));
			@(posedge mclk) port_in <= v;
			repeat (10) @(posedge mclk);
			cmp("int_oe", {7'h00, |((a ^ v) & ~b)}, {7'h00, int_oe});
			cmp("int_out", 8'h00, {7'h00, int_out});
			rd(CMD_INT_STAT, d);
			cmp("status", (a ^ v) & ~b, d);
		end
		wr(CMD_LATCH, RST_ONES);
		rd(CMD_INPUT, d);
		a = port_in;
		@(posedge mclk) port_in <= ~a;
		repeat (10) @(posedge mclk);
		@(posedge mclk) port_in <= a;
		repeat (10) @(posedge mclk);
		rd(CMD_INPUT, d);
		cmp("latched", exp_in(~a, sh[1]), d);
		rd(CMD_INPUT, d);
		cmp("released", exp_in(a, sh[1]), d);
		m.wr_reg(dev ^ 7'h01, CMD_OUTPUT, ~sh[0], ok);
		cmp("foreign ack", 8'h00, {7'h00, ok});
		cmp("port_out", sh[0], port_out);
		m.rd_two(dev, CMD_OUTPUT, d, v);
		cmp("burst byte 0", sh[0], d);
		cmp("burst byte 1", sh[0], v);
		summarize();
	end
endmodule : gpio_expander_test
